// ==== verilog/hfb_pkg.sv ====
package hfb_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_SLAVE_SEL = 8'h50;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h51;
  localparam logic [7:0] OFF_ADDR_LOW  = 8'h52;
  localparam logic [7:0] OFF_TRANS     = 8'h53;
  localparam logic [7:0] OFF_ERR_STAT  = 8'h54;
  localparam logic [7:0] OFF_ENABLE    = 8'h55;
  localparam logic [7:0] OFF_WDATA     = 8'h56;
  localparam logic [7:0] OFF_RDATA     = 8'hCC;

  // ==========================================================
  // Field positions
  localparam int TR_VID_ERR  = 6;
  localparam int TR_PF_DONE  = 5;
  localparam int TR_TYPE_LSB = 3;
  localparam int ES_FB       = 7;
  localparam int ES_SENS     = 6;
  localparam int ES_DEC      = 5;
  localparam int ES_ENC      = 4;
  localparam int ES_WR_REQ   = 3;
  localparam int ES_VID_REQ  = 2;
  localparam int ES_UNDERRUN = 1;
  localparam int ES_GNT      = 0;
  localparam int EN_VBYP     = 5;
  localparam int EN_ADBG     = 4;
  localparam int EN_RAW      = 3;
  localparam int EN_ARST     = 2;
  localparam int EN_AUDIO    = 1;
  localparam int EN_HWR      = 0;

  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [63:0] RST_QWORD    = 64'h0;
  localparam logic [14:0] AUDIO_BASE   = 15'h7E00;
  localparam int          PREFETCH_QW  = 2;
  localparam logic [2:0]  LAST_BYTE    = 3'h7;

  typedef enum logic [1:0] {
    TR_NONE  = 2'b00,
    TR_AUDIO = 2'b01,
    TR_VIDEO = 2'b10,
    TR_HWR   = 2'b11
  } hfb_trans_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ  = 2'b01,
    ST_WAIT = 2'b11
  } hfb_state_e;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hfb_reg_req_s;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        audio;
    logic [14:0] addr;
    logic [63:0] wdata;
  } hfb_fb_req_s;

  typedef struct packed {
    logic        grant;
    logic        deny;
    logic        rvalid;
    logic [63:0] rdata;
  } hfb_fb_rsp_s;

  typedef struct packed {
    logic video_bypass;
    logic audio_debug_readout;
    logic unencoded_audio;
    logic audio_pointer_restart;
    logic audio_enable;
    logic host_write_enable;
  } hfb_ctrl_s;

  typedef struct packed {
    logic       audio_buffer_empty;
    logic       audio_ptr_changed;
    logic       audio_ptr_reset_done;
    logic       sensor_err_any;
    logic       decoder_err_any;
    logic       encoder_err_any;
    logic [1:0] host_if_select;
  } hfb_stat_s;

endpackage

// ==== verilog/hfb_access.sv ====
`timescale 1ns/1ps
// What this block does
// - Low qword address byte, read-write
// - Upper seven qword address bits, read-write
// - Byte pointer selects start byte, video only
// - Two-bit field: none, audio, video, write
// - Audio or video transaction write prefetches two qwords
// - Transaction write sets prefetch-done flag
// - Audio buffer empty clears field of audio transaction
// - Video request into audio region flags error
// - Host write into audio region flags error
// - Empty read sets underrun, write-one clears
// - Refused grant sets error, write-one clears
// - Four read-only error summary flags
// - Video bypass skips conversion and compression
// - Audio debug readout, self-clears on pointers
// - Raw audio bypasses encoder
// - Audio restart resets pointers, self-clears
// - Audio enable reserves audio region
// - Host writes accepted only when enabled
// - Read data returns next frame byte
// - Report active control port selection
module hfb_access
  import hfb_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // Register port
  input  wire hfb_reg_req_s reg_req,
  output logic [7:0]        reg_rdata,
  // Frame buffer port
  output hfb_fb_req_s       fb_req,
  input  wire hfb_fb_rsp_s  fb_rsp,
  // Block controls and status
  output hfb_ctrl_s         ctrl,
  input  wire hfb_stat_s    stat
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [6:0]                   addr_hi;
    logic [7:0]                   addr_lo;
    logic [2:0]                   byte_ptr;
    hfb_trans_e                   trans;
    logic                         pf_done;
    logic                         vid_err;
    logic                         wr_err;
    logic                         undr;
    logic                         gnt_err;
    hfb_ctrl_s                    ctl;
    logic [7:0]                   wdata;
    logic [7:0]                   rdata;
    logic [PREFETCH_QW-1:0][63:0] qbuf;
    logic [PREFETCH_QW-1:0]       qvalid;
    logic                         rd_slot;
    logic                         fill_slot;
    logic [2:0]                   pos;
    logic [14:0]                  fetch_addr;
    logic [63:0]                  wq;
    logic                         wfull;
    logic                         req_wr;
    hfb_state_e                   st;
  } hfb_state_s;

  hfb_state_s q;
  hfb_state_s d;

  logic       wr_hit;
  logic       rd_hit;
  logic       wdata_hit;
  logic       rdata_hit;
  logic       trans_hit;
  logic       is_read;
  logic       can_read;
  logic       can_write;
  logic       bad_addr;
  logic [1:0] new_trans;

  // Read-back bytes
  logic [7:0] err_byte;
  logic [7:0] tr_byte;
  logic [7:0] en_byte;
  logic [7:0] rd_byte;
  logic [7:0] rd_mux;

  always_comb begin
    // ==========================================================
    // Decode
    wr_hit    = reg_req.wr;
    rd_hit    = reg_req.rd;
    wdata_hit = wr_hit && (reg_req.addr == OFF_WDATA);
    rdata_hit = rd_hit && (reg_req.addr == OFF_RDATA);
    trans_hit = wr_hit && (reg_req.addr == OFF_TRANS);
    is_read   = (q.trans == TR_AUDIO) || (q.trans == TR_VIDEO);
    // A byte is served only from a slot that the prefetch has filled
    can_read  = is_read && q.qvalid[q.rd_slot];
    // Bytes arriving while a qword waits for its grant are dropped
    can_write = q.ctl.host_write_enable && (q.trans == TR_HWR) && !q.wfull;
    new_trans = reg_req.wdata[TR_TYPE_LSB +: 2];
    // Only the start address is checked; a burst that runs up into the
    // audio region from below is not caught
    bad_addr  = q.ctl.audio_enable && ({q.addr_hi, q.addr_lo} >= AUDIO_BASE);

    // ==========================================================
    // Read-back bytes
    err_byte  = RST_BYTE;
    err_byte[ES_FB]       = q.wr_err | q.vid_err | q.undr | q.gnt_err;
    err_byte[ES_SENS]     = stat.sensor_err_any;
    err_byte[ES_DEC]      = stat.decoder_err_any;
    err_byte[ES_ENC]      = stat.encoder_err_any;
    err_byte[ES_WR_REQ]   = q.wr_err;
    err_byte[ES_VID_REQ]  = q.vid_err;
    err_byte[ES_UNDERRUN] = q.undr;
    err_byte[ES_GNT]      = q.gnt_err;
    tr_byte                   = RST_BYTE;
    tr_byte[TR_VID_ERR]       = q.vid_err;
    tr_byte[TR_PF_DONE]       = q.pf_done;
    tr_byte[TR_TYPE_LSB +: 2] = q.trans;
    tr_byte[2:0]              = q.byte_ptr;
    // Write-only strobes read back as zero
    en_byte                   = RST_BYTE;
    en_byte[EN_VBYP]          = q.ctl.video_bypass;
    en_byte[EN_RAW]           = q.ctl.unencoded_audio;
    en_byte[EN_AUDIO]         = q.ctl.audio_enable;
    en_byte[EN_HWR]           = q.ctl.host_write_enable;
    rd_byte                   = q.qbuf[q.rd_slot][{q.pos, 3'b000} +: 8];
    d = q;

    // ==========================================================
    // Configuration writes; read-only fields are not touched
    if (wr_hit) begin
      case (reg_req.addr)
        OFF_ADDR_HIGH: d.addr_hi = reg_req.wdata[6:0];
        OFF_ADDR_LOW:  d.addr_lo = reg_req.wdata;
        OFF_ERR_STAT: begin
          // Clears first so a same-cycle hardware set below wins
          if (reg_req.wdata[ES_UNDERRUN]) begin
            d.undr = 1'b0;
          end
          if (reg_req.wdata[ES_GNT]) begin
            d.gnt_err = 1'b0;
          end
        end
        OFF_ENABLE: begin
          d.ctl.video_bypass          = reg_req.wdata[EN_VBYP];
          d.ctl.unencoded_audio       = reg_req.wdata[EN_RAW];
          d.ctl.audio_enable          = reg_req.wdata[EN_AUDIO];
          d.ctl.host_write_enable     = reg_req.wdata[EN_HWR];
          d.ctl.audio_debug_readout   = reg_req.wdata[EN_ADBG];
          d.ctl.audio_pointer_restart = reg_req.wdata[EN_ARST];
        end
        default: ;
      endcase
    end

    // Self-clearing controls; a fresh write in the same cycle is lost
    // for good, since the clear below wins and the pointer event already happened
    if (stat.audio_ptr_changed) begin
      d.ctl.audio_debug_readout = 1'b0;
    end
    if (stat.audio_ptr_reset_done) begin
      d.ctl.audio_pointer_restart = 1'b0;
    end

    // ==========================================================
    // Frame buffer request sequencer
    case (q.st)
      ST_IDLE: begin
        // Writes go first so a full qword never waits behind a refill;
        // it is held back while host writes are disabled
        if (q.wfull && q.ctl.host_write_enable) begin
          d.req_wr = 1'b1;
          d.st     = ST_REQ;
        end else if (is_read && !(&q.qvalid)) begin
          d.req_wr    = 1'b0;
          d.fill_slot = q.qvalid[q.rd_slot] ? ~q.rd_slot : q.rd_slot;
          d.st        = ST_REQ;
        end
      end
      ST_REQ: begin
        if (fb_rsp.grant) begin
          if (q.req_wr) begin
            d.wfull      = 1'b0;
            d.fetch_addr = q.fetch_addr + 15'h1;
            d.st         = ST_IDLE;
          end else begin
            d.st = ST_WAIT;
          end
        end else if (fb_rsp.deny) begin
          // Retried from idle on the next cycle
          d.gnt_err = 1'b1;
          d.st      = ST_IDLE;
        end
      end
      ST_WAIT: begin
        // Only taken here: a late answer to a request dropped by a new
        // transaction write arrives in idle or request and is ignored
        if (fb_rsp.rvalid) begin
          d.qbuf[q.fill_slot]   = fb_rsp.rdata;
          d.qvalid[q.fill_slot] = 1'b1;
          d.fetch_addr          = q.fetch_addr + 15'h1;
          d.st                  = ST_IDLE;
        end
      end
      default: d.st = ST_IDLE;
    endcase

    // ==========================================================
    // Byte streaming through the data registers
    if (wdata_hit) begin
      d.wdata = reg_req.wdata;
      if (can_write) begin
        d.wq[{q.pos, 3'b000} +: 8] = reg_req.wdata;
        d.pos = q.pos + 3'h1;
        if (q.pos == LAST_BYTE) begin
          d.wfull = 1'b1;
        end
      end
    end
    rd_mux = RST_BYTE;
    case (reg_req.addr)
      OFF_SLAVE_SEL: rd_mux = {6'h00, stat.host_if_select};
      OFF_ADDR_HIGH: rd_mux = {1'b0, q.addr_hi};
      OFF_ADDR_LOW:  rd_mux = q.addr_lo;
      OFF_TRANS:     rd_mux = tr_byte;
      OFF_ERR_STAT:  rd_mux = err_byte;
      OFF_ENABLE:    rd_mux = en_byte;
      OFF_WDATA:     rd_mux = q.wdata;
      OFF_RDATA:     rd_mux = rd_byte;
      default:       rd_mux = RST_BYTE;
    endcase
    if (rd_hit) begin
      d.rdata = rd_mux;
      if (rdata_hit) begin
        if (can_read) begin
          d.pos = q.pos + 3'h1;
          if (q.pos == LAST_BYTE) begin
            d.qvalid[q.rd_slot] = 1'b0;
            d.rd_slot           = ~q.rd_slot;
          end
        end else begin
          d.rdata = RST_BYTE;
          d.undr  = 1'b1;
        end
      end
    end

    // ==========================================================
    // Audio transfer ends when the audio buffer runs dry
    if ((q.trans == TR_AUDIO) && stat.audio_buffer_empty) begin
      d.trans = TR_NONE;
    end

    // ==========================================================
    // Transaction control write restarts the stream
    // Any transaction write drops both slots and a part-filled write qword
    if (trans_hit) begin
      d.byte_ptr   = reg_req.wdata[2:0];
      d.trans      = hfb_trans_e'(new_trans);
      d.pf_done    = 1'b1;
      d.qvalid     = '0;
      d.rd_slot    = 1'b0;
      d.wfull      = 1'b0;
      d.st         = ST_IDLE;
      d.fetch_addr = {q.addr_hi, q.addr_lo};
      d.pos        = (new_trans == TR_VIDEO) ? reg_req.wdata[2:0] : 3'h0;
      if (new_trans == TR_VIDEO) begin
        d.vid_err = bad_addr;
      end
      if (new_trans == TR_HWR) begin
        d.wr_err = bad_addr;
      end
      // A rejected request leaves no transaction running
      if (bad_addr && ((new_trans == TR_VIDEO) || (new_trans == TR_HWR))) begin
        d.trans = TR_NONE;
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q    <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    reg_rdata    = q.rdata;
    ctrl         = q.ctl;
    fb_req.valid = (q.st == ST_REQ);
    fb_req.write = q.req_wr;
    // Audio reads follow the far side's own audio pointer, not fb_req.addr
    fb_req.audio = (q.trans == TR_AUDIO) || q.ctl.audio_debug_readout;
    fb_req.addr  = q.fetch_addr;
    fb_req.wdata = q.wq;
  end

endmodule

// ==== sim/hfb_sva.sv ====
`timescale 1ns/1ps
module hfb_sva
  import hfb_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         rst,
  // Watched ports
  input wire hfb_reg_req_s reg_req,
  input wire logic [7:0]   reg_rdata,
  input wire hfb_fb_req_s  fb_req,
  input wire hfb_fb_rsp_s  fb_rsp,
  input wire hfb_ctrl_s    ctrl,
  input wire hfb_stat_s    stat
);
  // ==========================================================
  // Properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  wire wr_tr = reg_req.wr && reg_req.addr == OFF_TRANS;
  property p_pf;
    wr_tr && reg_req.wdata[4:3] == TR_VIDEO && !ctrl.audio_enable && !fb_req.valid
      |-> ##[1:6] fb_req.valid;
  endproperty
  a_pf: assert property (p_pf) else $error("no prefetch");
  property p_wen;
    fb_req.valid && fb_req.write |-> ctrl.host_write_enable;
  endproperty
  a_wen: assert property (p_wen) else $error("write while off");
  property p_reg;
    fb_req.valid && !fb_req.audio && ctrl.audio_enable |-> fb_req.addr < AUDIO_BASE;
  endproperty
  a_reg: assert property (p_reg) else $error("audio region hit");
  property p_sum;
    reg_req.rd && reg_req.addr == OFF_ERR_STAT |=> reg_rdata[ES_FB] == (|reg_rdata[3:0])
      && reg_rdata[ES_SENS] == $past(stat.sensor_err_any);
  endproperty
  a_sum: assert property (p_sum) else $error("bad summary");
  property p_sel;
    reg_req.rd && reg_req.addr == OFF_SLAVE_SEL |=> reg_rdata[1:0] == $past(stat.host_if_select);
  endproperty
  a_sel: assert property (p_sel) else $error("bad select");
  property p_stand;
    !reg_req.rd |=> $stable(reg_rdata);
  endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_arst;
    ctrl.audio_pointer_restart && stat.audio_ptr_reset_done |=> !ctrl.audio_pointer_restart;
  endproperty
  a_arst: assert property (p_arst) else $error("restart stuck");
  property p_en;
    reg_req.wr && reg_req.addr == OFF_ENABLE && !stat.audio_ptr_changed
      && !stat.audio_ptr_reset_done |=> ctrl == $past(reg_req.wdata[5:0]);
  endproperty
  a_en: assert property (p_en) else $error("bad controls");
  property p_adbg;
    ctrl.audio_debug_readout && stat.audio_ptr_changed |=> !ctrl.audio_debug_readout;
  endproperty
  a_adbg: assert property (p_adbg) else $error("debug readout stuck");
  c_deny: cover property (fb_req.valid && fb_rsp.deny);
  c_wr: cover property (fb_req.write && fb_rsp.grant);
  c_rv: cover property (fb_rsp.rvalid);
endmodule

// ==== sim/hfb_fb_model.sv ====
`timescale 1ns/1ps
module hfb_fb_model
  import hfb_pkg::*;
(
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Device side
  input wire hfb_fb_req_s fb_req,
  output hfb_fb_rsp_s     fb_rsp,
  // Test controls and results
  input wire logic        deny_en,
  input wire logic        slow,
  output logic [63:0]     wr_qword,
  output logic [7:0]      wr_cnt,
  output logic [7:0]      rd_cnt
);
  logic [1:0]  wait_q;
  logic        pend_q;
  logic [14:0] addr_q;
  // Byte k of qword a holds {a[4:0], k}
  function automatic logic [63:0] pat(input logic [14:0] a);
    for (int k = 0; k < 8; k++) begin
      pat[k*8 +: 8] = {a[4:0], 3'(k)};
    end
  endfunction
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fb_rsp   <= '0;
      wait_q   <= 2'h0;
      pend_q   <= 1'b0;
      addr_q   <= 15'h0;
      wr_qword <= 64'h0;
      wr_cnt   <= 8'h0;
      rd_cnt   <= 8'h0;
    end else begin
      fb_rsp.grant  <= 1'b0;
      fb_rsp.deny   <= 1'b0;
      fb_rsp.rvalid <= pend_q;
      // Data lines wander outside a response
      fb_rsp.rdata  <= pend_q ? pat(addr_q) : ~fb_rsp.rdata;
      pend_q        <= 1'b0;
      rd_cnt        <= rd_cnt + 8'(pend_q);
      if (fb_req.valid && !fb_rsp.grant && !fb_rsp.deny) begin
        wait_q <= wait_q + 2'h1;
        if (deny_en) begin
          fb_rsp.deny <= 1'b1;
        end else if (!slow || wait_q == 2'h3) begin
          fb_rsp.grant <= 1'b1;
          wait_q       <= 2'h0;
          pend_q       <= !fb_req.write;
          addr_q       <= fb_req.addr;
          if (fb_req.write) begin
            wr_qword <= fb_req.wdata;
            wr_cnt   <= wr_cnt + 8'h01;
          end
        end
      end
    end
  end
endmodule

// ==== sim/hfb_access_tb.sv ====
`timescale 1ns/1ps
module hfb_access_tb
  import hfb_pkg::*;
();
  logic         clock, rst, deny_en, slow;
  hfb_reg_req_s reg_req;
  logic [7:0]   reg_rdata, wr_cnt, rd_cnt;
  hfb_fb_req_s  fb_req;
  hfb_fb_rsp_s  fb_rsp;
  hfb_ctrl_s    ctrl;
  hfb_stat_s    stat;
  logic [63:0]  wr_qword;
  int           failures = 0, compares = 0, cycles = 0;
  hfb_access i_hfb_access (.clock, .rst, .reg_req, .reg_rdata, .fb_req, .fb_rsp, .ctrl, .stat);
  hfb_fb_model i_hfb_fb_model (.clock, .rst, .fb_req, .fb_rsp, .deny_en, .slow, .wr_qword,
    .wr_cnt, .rd_cnt);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      print_verdict();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= '{1'b0, 1'b1, a, d};
    @(posedge clock);
    reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_req <= '{1'b1, 1'b0, a, 8'h00};
    @(posedge clock);
    reg_req <= '0;
    @(posedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic burst();
    for (int k = 0; k < 8; k++) begin
      wr(OFF_WDATA, 8'h30 + 8'(k));
    end
    repeat (40) @(posedge clock);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_video();
    slow <= 1'b1;
    wr(OFF_ADDR_HIGH, 8'hFF);
    rd(OFF_ADDR_HIGH, 8'h7F);
    wr(OFF_ADDR_HIGH, 8'h00);
    wr(OFF_ADDR_LOW, 8'h10);
    rd(OFF_ADDR_LOW, 8'h10);
    wr(OFF_TRANS, 8'h15);
    rd(OFF_TRANS, 8'h35);
    repeat (80) if (rd_cnt < 8'h02) @(posedge clock);
    for (int k = 5; k < 16; k++) begin
      rd(OFF_RDATA, 8'h80 + 8'(k));
    end
  endtask
  task automatic t_under();
    wr(OFF_TRANS, 8'h00);
    rd(OFF_RDATA, 8'h00);
    rd(OFF_ERR_STAT, 8'h82);
    wr(OFF_ERR_STAT, 8'h00);
    rd(OFF_ERR_STAT, 8'h82);
    wr(OFF_ERR_STAT, 8'h02);
    rd(OFF_ERR_STAT, 8'h00);
  endtask
  task automatic t_write();
    slow <= 1'b0;
    wr(OFF_ENABLE, 8'h01);
    wr(OFF_TRANS, 8'h18);
    burst();
    chk("wr_cnt", 8'h01, wr_cnt);
    chk("byte0", 8'h30, wr_qword[7:0]);
    chk("byte7", 8'h37, wr_qword[63:56]);
    rd(OFF_WDATA, 8'h37);
    wr(OFF_ENABLE, 8'h00);
    burst();
    chk("wr_cnt", 8'h01, wr_cnt);
  endtask
  task automatic t_deny();
    deny_en <= 1'b1;
    wr(OFF_TRANS, 8'h10);
    repeat (30) if (!fb_rsp.deny) @(posedge clock);
    deny_en <= 1'b0;
    rd(OFF_ERR_STAT, 8'h81);
    wr(OFF_ERR_STAT, 8'h01);
    rd(OFF_ERR_STAT, 8'h00);
  endtask
  task automatic t_ctrl();
    stat <= 8'h9F;
    wr(OFF_ENABLE, 8'h3F);
    rd(OFF_ENABLE, 8'h2B);
    stat <= 8'hFF;
    rd(OFF_ERR_STAT, 8'h70);
    stat <= 8'h83;
  endtask
  task automatic t_region();
    wr(OFF_ENABLE, 8'h03);
    wr(OFF_ADDR_HIGH, 8'h7E);
    wr(OFF_ADDR_LOW, 8'h00);
    wr(OFF_TRANS, 8'h18);
    rd(OFF_ERR_STAT, 8'h88);
    wr(OFF_TRANS, 8'h10);
    rd(OFF_TRANS, 8'h60);
    wr(OFF_ADDR_HIGH, 8'h00);
    wr(OFF_TRANS, 8'h10);
    rd(OFF_TRANS, 8'h30);
  endtask
  task automatic t_audio();
    stat <= 8'h03;
    wr(OFF_TRANS, 8'h08);
    rd(OFF_TRANS, 8'h28);
    stat <= 8'h83;
    rd(OFF_TRANS, 8'h20);
  endtask
  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    reg_req = '0;
    deny_en = 1'b0;
    slow = 1'b0;
    stat = 8'h83;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(OFF_SLAVE_SEL, 8'h03);
    rd(OFF_ERR_STAT, 8'h00);
    t_video();
    t_under();
    t_write();
    t_deny();
    t_ctrl();
    t_region();
    t_audio();
    print_verdict();
  end
endmodule
bind hfb_access hfb_sva i_hfb_sva (.clock, .rst, .reg_req, .reg_rdata, .fb_req, .fb_rsp, .ctrl,
  .stat);
